/* File: lsf_byte_rx.sv */
/*
  Serial byte sampler: start bit, eight data bits LSB first, stop bit.
  Assumes start_i pulses on the detected falling edge of the start bit.
*/
`timescale 1ns/1ps
module lsf_byte_rx (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  input wire logic start_i,
  input wire logic line_i,
  input wire logic [15:0] bit_period_i,
  output logic done_o,
  output logic [7:0] data_o,
  output logic frame_ok_o
);
  logic [15:0] cnt_q;
  logic [3:0] idx_q;
  logic active_q;

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      cnt_q <= 16'h0000;
      idx_q <= 4'h0;
      active_q <= 1'b0;
      done_o <= 1'b0;
      data_o <= 8'h00;
      frame_ok_o <= 1'b0;
    end else if (clk_en_i) begin
      done_o <= 1'b0;
      if (start_i && !active_q) begin
        // First sample lands mid start bit
        active_q <= 1'b1;
        idx_q <= 4'h0;
        cnt_q <= {1'b0, bit_period_i[15:1]};
        frame_ok_o <= 1'b1;
      end else if (active_q) begin
        if (cnt_q <= 16'h0001) begin
          // Full reload: the <= 1 test already spends the sample edge
          cnt_q <= bit_period_i;
          idx_q <= idx_q + 4'h1;
          case (idx_q)
            4'h0: frame_ok_o <= frame_ok_o & ~line_i;
            4'h9: begin
              frame_ok_o <= frame_ok_o & line_i;
              done_o <= 1'b1;
              active_q <= 1'b0;
            end
            default: data_o <= {line_i, data_o[7:1]};
          endcase
        end else begin
          cnt_q <= cnt_q - 16'h0001;
        end
      end
    end
  end
endmodule : lsf_byte_rx

/* File: lsf_lin_commander.sv */
/*
  LIN commander model: break, delimiter, sync byte, one data byte on the receive line.
  Assumes the receiver was set to BIT_CYC system clocks per bit; line idles high.
*/
`timescale 1ns/1ps
module lsf_lin_commander #(
  parameter int BIT_CYC = 16
) (
  input wire logic clk_sys_i,
  output logic line_o
);
  initial line_o = 1'b1;

  task automatic hold(input logic lvl, input int n);
    line_o <= lvl;
    repeat (n) @(posedge clk_sys_i);
  endtask : hold

  // Glitch puts a short low pulse in bit 0, clear of the mid-bit sample
  task automatic send_byte(input logic [7:0] val, input bit glitch);
    hold(1'b0, BIT_CYC);
    if (glitch) begin
      hold(1'b1, 3);
      hold(1'b0, 2);
      hold(1'b1, BIT_CYC - 5);
    end else begin
      hold(val[0], BIT_CYC);
    end
    for (int i = 1; i < 8; i++) begin
      hold(val[i], BIT_CYC);
    end
    hold(1'b1, BIT_CYC);
  endtask : send_byte

  task automatic send_frame(input logic [7:0] sync, input logic [7:0] data,
                            input bit blank, input bit glitch);
    @(posedge clk_sys_i);
    // Break two bits over the minimum, then delimiter
    hold(1'b0, 13 * BIT_CYC);
    hold(1'b1, BIT_CYC);
    if (blank) begin
      hold(1'b1, 24 * BIT_CYC);
    end else begin
      send_byte(sync, glitch);
      hold(1'b1, BIT_CYC);
      send_byte(data, 1'b0);
      hold(1'b1, 2 * BIT_CYC);
    end
  endtask : send_frame
endmodule : lsf_lin_commander

/* File: lsf_pkg.sv */
/*
  Constants, field layout and state type of the LIN sync-field checker.
  Assumes a 200 MHz system clock and an AXI4-Lite register bus.
*/
// Contract
// - Only a received sync byte equal to 55 hex counts as valid.
// - A wrong sync value leaves the inconsistent-sync flag clear, no interrupt.
// - After a wrong sync value the frame is dropped, no data, no receive interrupt.
// - Blank sync fields and out-of-tolerance sync timing are still flagged.
// - Busy sets when frame activity starts, before any receive-ready.
// - A complete frame with correct sync sets receive-ready and interrupts.
package lsf_pkg;
  localparam int CLK_HZ = 200_000_000;
  localparam int BAUD_DEFAULT = 19_200;
  localparam logic [15:0] BIT_CYC_RST = 16'(CLK_HZ / BAUD_DEFAULT);

  localparam logic [7:0] SYNC_VALUE = 8'h55;
  // Break must be at least this many bit times low
  localparam logic [4:0] BREAK_BITS = 5'h0B;
  // Longest idle gap before a field counts as missing
  localparam logic [4:0] GAP_BITS = 5'h14;
  // Falling edges of a good sync byte span eight bit times, +/- one
  localparam logic [4:0] SPAN_BITS = 5'h08;
  localparam logic [2:0] SYNC_FALLS = 3'h5;

  localparam int AXI_AW = 8;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_BITPER = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_MASK = 8'h0C;
  localparam logic [7:0] OFF_RXDATA = 8'h10;
  localparam logic [7:0] OFF_SYNCVAL = 8'h14;

  localparam logic [2:0] SEL_CTRL = 3'h0;
  localparam logic [2:0] SEL_BITPER = 3'h1;
  localparam logic [2:0] SEL_STATUS = 3'h2;
  localparam logic [2:0] SEL_MASK = 3'h3;
  localparam logic [2:0] SEL_RXDATA = 3'h4;
  localparam logic [2:0] SEL_SYNCVAL = 3'h5;
  localparam logic [2:0] SEL_NONE = 3'h7;

  localparam int CTRL_EN = 0;
  localparam int STS_BUSY = 0;
  localparam int STS_EVT_LO = 1;
  localparam int STS_ISE = 4;
  localparam int EVT_W = 3;
  localparam int EVT_RECEIVE_WORD_READY = 0;
  localparam int EVT_BLANK = 1;
  localparam int EVT_TIMING = 2;

  localparam logic CTRL_EN_RST = 1'b1;
  localparam logic [EVT_W-1:0] MASK_RST = 3'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_BREAK = 3'h1,
    ST_DELIM = 3'h3,
    ST_SYNC = 3'h2,
    ST_RESP = 3'h6
  } lsf_state_type;
endpackage : lsf_pkg

/* File: lsf_sticky.sv */
/*
  Sticky event flags, set by hardware, cleared by writing one.
  Assumes set and clear are single-cycle pulses on the system clock.
*/
`timescale 1ns/1ps
module lsf_sticky #(
  parameter int W = 3
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  input wire logic [W-1:0] set_i,
  input wire logic [W-1:0] clr_i,
  output logic [W-1:0] q_o
);
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
          q_o[g] <= 1'b0;
        end else if (clk_en_i) begin
          // Set beats a simultaneous clear
          if (set_i[g]) begin
            q_o[g] <= 1'b1;
          end else if (clr_i[g]) begin
            q_o[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate
endmodule : lsf_sticky

/* File: lsf_sync_check.sv */
/*
  LIN receive front end with sync-field checking, as the affected silicon behaves:
  a wrong sync value silently drops the frame. Registers over AXI4-Lite.
  Assumes bus_receive_line_i is already synchronous to clk_sys_i, idle high.
*/
// Local design decisions: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
module lsf_sync_check (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  input wire logic bus_receive_line_i,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic busy_o,
  output logic [7:0] rx_data_o,
  output logic irq_o
);
  lsf_pkg::lsf_state_type state_q;
  logic line_q;
  logic fall;
  logic rise;
  logic [23:0] cnt_q;
  logic [2:0] falls_q;
  logic [23:0] span_q;
  logic rx_active_q;
  logic rx_start;
  logic rx_done;
  logic [7:0] rx_byte;
  logic rx_ok;
  logic [7:0] sync_val_q;
  logic enable_q;
  logic [15:0] bit_per_q;
  logic [lsf_pkg::EVT_W-1:0] mask_q;
  logic [lsf_pkg::EVT_W-1:0] evt_set;
  logic [lsf_pkg::EVT_W-1:0] evt_clr;
  logic [lsf_pkg::EVT_W-1:0] evt_q;
  logic aw_hold_q;
  logic w_hold_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic do_write;
  logic [2:0] wsel;

  // Register index from byte address; used by both bus paths
  function automatic logic [2:0] reg_sel(input logic [7:0] addr);
    case (addr)
      lsf_pkg::OFF_CTRL: reg_sel = lsf_pkg::SEL_CTRL;
      lsf_pkg::OFF_BITPER: reg_sel = lsf_pkg::SEL_BITPER;
      lsf_pkg::OFF_STATUS: reg_sel = lsf_pkg::SEL_STATUS;
      lsf_pkg::OFF_MASK: reg_sel = lsf_pkg::SEL_MASK;
      lsf_pkg::OFF_RXDATA: reg_sel = lsf_pkg::SEL_RXDATA;
      lsf_pkg::OFF_SYNCVAL: reg_sel = lsf_pkg::SEL_SYNCVAL;
      default: reg_sel = lsf_pkg::SEL_NONE;
    endcase
  endfunction : reg_sel

  // Bit-time multiple of the programmed period
  function automatic logic [23:0] bit_times(input logic [15:0] per, input logic [4:0] n);
    bit_times = 24'({8'h00, per} * {19'h00000, n});
  endfunction : bit_times

  assign fall = line_q & ~bus_receive_line_i;
  assign rise = ~line_q & bus_receive_line_i;
  assign busy_o = (state_q != lsf_pkg::ST_IDLE);

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      line_q <= 1'b1;
    end else if (clk_en_i) begin
      line_q <= bus_receive_line_i;
    end
  end

  assign rx_start = fall && ((state_q == lsf_pkg::ST_DELIM)
                    || (state_q == lsf_pkg::ST_RESP && !rx_active_q));

  lsf_byte_rx u_byte_rx (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .clk_en_i(clk_en_i),
    .start_i(rx_start),
    .line_i(bus_receive_line_i),
    .bit_period_i(bit_per_q),
    .done_o(rx_done),
    .data_o(rx_byte),
    .frame_ok_o(rx_ok)
  );

  // Frame sequencer
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      state_q <= lsf_pkg::ST_IDLE;
      cnt_q <= 24'h000000;
      rx_active_q <= 1'b0;
    end else if (clk_en_i) begin
      cnt_q <= cnt_q + 24'h000001;
      case (state_q)
        lsf_pkg::ST_IDLE: begin
          cnt_q <= 24'h000000;
          rx_active_q <= 1'b0;
          if (enable_q && fall) begin
            state_q <= lsf_pkg::ST_BREAK;
          end
        end
        lsf_pkg::ST_BREAK: begin
          if (rise) begin
            cnt_q <= 24'h000000;
            if (cnt_q >= bit_times(bit_per_q, lsf_pkg::BREAK_BITS)) begin
              state_q <= lsf_pkg::ST_DELIM;
            end else begin
              state_q <= lsf_pkg::ST_IDLE;
            end
          end
        end
        lsf_pkg::ST_DELIM: begin
          if (fall) begin
            cnt_q <= 24'h000000;
            state_q <= lsf_pkg::ST_SYNC;
          end else if (cnt_q >= bit_times(bit_per_q, lsf_pkg::GAP_BITS)) begin
            state_q <= lsf_pkg::ST_IDLE;
          end
        end
        lsf_pkg::ST_SYNC: begin
          if (rx_done) begin
            cnt_q <= 24'h000000;
            if (rx_ok && rx_byte == lsf_pkg::SYNC_VALUE && !evt_set[lsf_pkg::EVT_TIMING]) begin
              state_q <= lsf_pkg::ST_RESP;
            end else begin
              state_q <= lsf_pkg::ST_IDLE;
            end
          end
        end
        lsf_pkg::ST_RESP: begin
          if (rx_start) begin
            rx_active_q <= 1'b1;
          end else if (!rx_active_q
                       && cnt_q >= bit_times(bit_per_q, lsf_pkg::GAP_BITS)) begin
            // Missing response is dropped without a flag
            state_q <= lsf_pkg::ST_IDLE;
          end
          if (rx_done) begin
            state_q <= lsf_pkg::ST_IDLE;
          end
        end
        default: state_q <= lsf_pkg::ST_IDLE;
      endcase
    end
  end

  // Sync timing: span of the first to fifth falling edge
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      falls_q <= 3'h0;
      span_q <= 24'h000000;
    end else if (clk_en_i) begin
      if (state_q == lsf_pkg::ST_DELIM) begin
        falls_q <= 3'h1;
        span_q <= 24'h000000;
      end else if (state_q == lsf_pkg::ST_SYNC && fall && falls_q < lsf_pkg::SYNC_FALLS) begin
        falls_q <= falls_q + 3'h1;
        if (falls_q + 3'h1 == lsf_pkg::SYNC_FALLS) begin
          span_q <= cnt_q;
        end
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      sync_val_q <= 8'h00;
      rx_data_o <= 8'h00;
    end else if (clk_en_i && rx_done) begin
      if (state_q == lsf_pkg::ST_SYNC) begin
        sync_val_q <= rx_byte;
      end
      if (state_q == lsf_pkg::ST_RESP && rx_ok) begin
        rx_data_o <= rx_byte;
      end
    end
  end

  always_comb begin
    evt_set = '0;
    evt_set[lsf_pkg::EVT_RECEIVE_WORD_READY] = rx_done && rx_ok && state_q == lsf_pkg::ST_RESP;
    evt_set[lsf_pkg::EVT_BLANK] = state_q == lsf_pkg::ST_DELIM && !fall
      && cnt_q >= bit_times(bit_per_q, lsf_pkg::GAP_BITS);
    evt_set[lsf_pkg::EVT_TIMING] = state_q == lsf_pkg::ST_SYNC && rx_done && rx_ok
      && rx_byte == lsf_pkg::SYNC_VALUE
      && (span_q < bit_times(bit_per_q, lsf_pkg::SPAN_BITS - 5'h01)
          || span_q > bit_times(bit_per_q, lsf_pkg::SPAN_BITS + 5'h01));
  end

  lsf_sticky #(.W(lsf_pkg::EVT_W)) u_sticky (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .clk_en_i(clk_en_i),
    .set_i(evt_set),
    .clr_i(evt_clr),
    .q_o(evt_q)
  );

  assign irq_o = |(evt_q & mask_q);

  // AXI write channels, taken in either order
  assign s_axi_awready = clk_en_i & ~aw_hold_q & ~s_axi_bvalid;
  assign s_axi_wready = clk_en_i & ~w_hold_q & ~s_axi_bvalid;
  assign do_write = clk_en_i & aw_hold_q & w_hold_q & ~s_axi_bvalid;
  assign wsel = reg_sel(awaddr_q);

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= lsf_pkg::RESP_OKAY;
    end else if (clk_en_i) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wsel == lsf_pkg::SEL_NONE) ? lsf_pkg::RESP_SLVERR : lsf_pkg::RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      enable_q <= lsf_pkg::CTRL_EN_RST;
      bit_per_q <= lsf_pkg::BIT_CYC_RST;
      mask_q <= lsf_pkg::MASK_RST;
    end else if (do_write) begin
      case (wsel)
        lsf_pkg::SEL_CTRL: begin
          if (wstrb_q[0]) begin
            enable_q <= wdata_q[lsf_pkg::CTRL_EN];
          end
        end
        lsf_pkg::SEL_BITPER: begin
          if (wstrb_q[0]) begin
            bit_per_q[7:0] <= wdata_q[7:0];
          end
          if (wstrb_q[1]) begin
            bit_per_q[15:8] <= wdata_q[15:8];
          end
        end
        lsf_pkg::SEL_MASK: begin
          if (wstrb_q[0]) begin
            mask_q <= wdata_q[lsf_pkg::STS_EVT_LO +: lsf_pkg::EVT_W];
          end
        end
        default: ;
      endcase
    end
  end

  assign evt_clr = (do_write && wsel == lsf_pkg::SEL_STATUS && wstrb_q[0])
                   ? wdata_q[lsf_pkg::STS_EVT_LO +: lsf_pkg::EVT_W] : '0;

  // AXI read: one outstanding read, data from a flop
  assign s_axi_arready = clk_en_i & ~s_axi_rvalid;

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= lsf_pkg::RESP_OKAY;
    end else if (clk_en_i) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= lsf_pkg::RESP_OKAY;
        case (reg_sel(s_axi_araddr))
          lsf_pkg::SEL_CTRL: s_axi_rdata[lsf_pkg::CTRL_EN] <= enable_q;
          lsf_pkg::SEL_BITPER: s_axi_rdata[15:0] <= bit_per_q;
          lsf_pkg::SEL_STATUS: begin
            s_axi_rdata[lsf_pkg::STS_BUSY] <= busy_o;
            s_axi_rdata[lsf_pkg::STS_EVT_LO +: lsf_pkg::EVT_W] <= evt_q;
            s_axi_rdata[lsf_pkg::STS_ISE] <= 1'b0;
          end
          lsf_pkg::SEL_MASK: s_axi_rdata[lsf_pkg::STS_EVT_LO +: lsf_pkg::EVT_W] <= mask_q;
          lsf_pkg::SEL_RXDATA: s_axi_rdata[7:0] <= rx_data_o;
          lsf_pkg::SEL_SYNCVAL: s_axi_rdata[7:0] <= sync_val_q;
          default: s_axi_rresp <= lsf_pkg::RESP_SLVERR;
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule : lsf_sync_check

/* File: lsf_sync_check_assertions.sv */
/*
  Port-level checks of lsf_sync_check: frame sequencing, data delivery, register bus.
  Assumes one clock domain and the enable register left at its reset value.
*/
`timescale 1ns/1ps
module lsf_sync_check_assertions (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  input wire logic bus_receive_line_i,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic busy_o,
  input wire logic [7:0] rx_data_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!reset_n_i);

  busy_start_a: assert property ($fell(bus_receive_line_i) && !busy_o && clk_en_i |=> busy_o)
    else $error("busy missing after line fall");
  busy_cause_a: assert property ($rose(busy_o) |-> $past(!bus_receive_line_i)
    && $past(bus_receive_line_i, 2)) else $error("busy rose without line fall");
  data_frame_a: assert property ($changed(rx_data_o) |-> $past(busy_o, 2))
    else $error("receive data changed outside a frame");
  irq_cause_a: assert property ($rose(irq_o) |-> (busy_o || $past(busy_o))
    or (##[0:2] s_axi_bvalid)) else $error("interrupt rose without event");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response dropped early");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read data dropped early");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  bad_read_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h14
    |=> s_axi_rresp == lsf_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
endmodule : lsf_sync_check_assertions

bind lsf_sync_check lsf_sync_check_assertions u_chk (.clk_sys_i(clk_sys_i),
  .reset_n_i(reset_n_i), .clk_en_i(clk_en_i), .bus_receive_line_i(bus_receive_line_i),
  .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .busy_o(busy_o), .rx_data_o(rx_data_o), .irq_o(irq_o));

/* File: tb.sv */
/*
  Self-checking bench for lsf_sync_check: register bus, good, wrong, blank, skewed frames.
  Assumes lsf_lin_commander as far side and a software-style frame timeout supervisor.
*/
`timescale 1ns/1ps
module tb;
  localparam int BIT_CYC = 16;
  logic clk_sys_i = 1'b0;
  logic reset_n_i, clk_en_i, line, line_q, busy_o, irq_o;
  logic [7:0] awaddr, araddr, rx_data_o;
  logic [31:0] wdata, rdata, rd;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp, resp;
  logic [7:0] bad[3] = '{8'h54, 8'hD5, 8'hAA};
  int n_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  int sup_cnt = 0;
  int sup_limit = 60 * BIT_CYC;
  bit sup_run = 0;
  bit sup_timeout = 0;

  always #2.5 clk_sys_i = ~clk_sys_i;

  lsf_sync_check u_dut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i),
    .bus_receive_line_i(line), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .busy_o(busy_o), .rx_data_o(rx_data_o), .irq_o(irq_o));
  lsf_lin_commander #(.BIT_CYC(BIT_CYC)) u_cmd (.clk_sys_i(clk_sys_i), .line_o(line));

  task automatic give_verdict();
    if (n_errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : give_verdict

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [7:0] addr, input logic [31:0] data);
    bit a_ok, w_ok, a, w, b;
    a_ok = 0;
    w_ok = 0;
    b = 0;
    @(posedge clk_sys_i);
    awaddr <= addr;
    awvalid <= 1'b1;
    wdata <= data;
    wvalid <= 1'b1;
    while (!(a_ok && w_ok)) begin
      @(negedge clk_sys_i);
      a = awvalid && awready;
      w = wvalid && wready;
      @(posedge clk_sys_i);
      if (a) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      a_ok |= a;
      w_ok |= w;
    end
    bready <= 1'b1;
    while (!b) begin
      @(negedge clk_sys_i);
      b = bvalid;
      resp = bresp;
      @(posedge clk_sys_i);
    end
    bready <= 1'b0;
  endtask : wr

  // Late rready so the slave must hold its answer
  task automatic rd_chk(input string name, input logic [7:0] addr, input logic [31:0] exp,
                        input logic [1:0] exp_resp);
    bit a, r;
    a = 0;
    r = 0;
    @(posedge clk_sys_i);
    araddr <= addr;
    arvalid <= 1'b1;
    while (!a) begin
      @(negedge clk_sys_i);
      a = arready;
      @(posedge clk_sys_i);
    end
    arvalid <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    rready <= 1'b1;
    while (!r) begin
      @(negedge clk_sys_i);
      r = rvalid;
      rd = rdata;
      resp = rresp;
      @(posedge clk_sys_i);
    end
    rready <= 1'b0;
    check(name, rd, exp);
    check({name, " resp"}, {30'h0, resp}, {30'h0, exp_resp});
  endtask : rd_chk

  always @(posedge clk_sys_i) begin
    line_q <= line;
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      give_verdict();
    end
    if (!sup_run && line_q && !line) begin
      sup_run <= 1'b1;
      sup_cnt <= 0;
    end else if (sup_run) begin
      if (sup_cnt == 2) check("busy", {31'h0, busy_o}, 32'h1);
      if (irq_o) sup_run <= 1'b0;
      else if (sup_cnt == sup_limit) begin
        sup_run <= 1'b0;
        sup_timeout <= 1'b1;
      end else sup_cnt <= sup_cnt + 1;
    end
  end

  initial begin
    {reset_n_i, awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
    clk_en_i = 1'b1;
    line_q = 1'b1;
    repeat (5) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    rd_chk("ctrl", lsf_pkg::OFF_CTRL, 32'h1, lsf_pkg::RESP_OKAY);
    rd_chk("bitper", lsf_pkg::OFF_BITPER, {16'h0, lsf_pkg::BIT_CYC_RST}, lsf_pkg::RESP_OKAY);
    rd_chk("mask", lsf_pkg::OFF_MASK, 32'h0, lsf_pkg::RESP_OKAY);
    rd_chk("status", lsf_pkg::OFF_STATUS, 32'h0, lsf_pkg::RESP_OKAY);
    rd_chk("unmapped", 8'h20, 32'h0, lsf_pkg::RESP_SLVERR);
    wr(8'h20, 32'hFF);
    check("unmapped write", {30'h0, resp}, {30'h0, lsf_pkg::RESP_SLVERR});
    clk_en_i <= 1'b0;
    @(posedge clk_sys_i);
    check("frozen ready", {29'h0, awready, wready, arready}, 32'h0);
    clk_en_i <= 1'b1;
    wr(lsf_pkg::OFF_BITPER, BIT_CYC);
    wr(lsf_pkg::OFF_MASK, 32'h2);
    u_cmd.send_frame(lsf_pkg::SYNC_VALUE, 8'hA3, 1'b0, 1'b0);
    repeat (4) @(posedge clk_sys_i);
    check("rx data", {24'h0, rx_data_o}, 32'hA3);
    check("rx irq", {31'h0, irq_o}, 32'h1);
    check("no timeout", {31'h0, sup_timeout}, 32'h0);
    rd_chk("ready", lsf_pkg::OFF_STATUS, 32'h2, lsf_pkg::RESP_OKAY);
    wr(lsf_pkg::OFF_STATUS, 32'h2);
    check("irq cleared", {31'h0, irq_o}, 32'h0);
    foreach (bad[i]) begin
      u_cmd.send_frame(bad[i], 8'h3C, 1'b0, 1'b0);
      repeat (500) @(posedge clk_sys_i);
      check("timeout", {31'h0, sup_timeout}, 32'h1);
      sup_timeout <= 1'b0;
      check("kept data", {24'h0, rx_data_o}, 32'hA3);
      check("no irq", {31'h0, irq_o}, 32'h0);
      rd_chk("no flags", lsf_pkg::OFF_STATUS, 32'h0, lsf_pkg::RESP_OKAY);
      rd_chk("sync seen", lsf_pkg::OFF_SYNCVAL, {24'h0, bad[i]}, lsf_pkg::RESP_OKAY);
    end
    wr(lsf_pkg::OFF_MASK, 32'h4);
    u_cmd.send_frame(8'h00, 8'h00, 1'b1, 1'b0);
    check("blank irq", {31'h0, irq_o}, 32'h1);
    rd_chk("blank", lsf_pkg::OFF_STATUS, 32'h4, lsf_pkg::RESP_OKAY);
    wr(lsf_pkg::OFF_MASK, 32'h8);
    check("masked", {31'h0, irq_o}, 32'h0);
    wr(lsf_pkg::OFF_STATUS, 32'h4);
    u_cmd.send_frame(lsf_pkg::SYNC_VALUE, 8'h3C, 1'b0, 1'b1);
    repeat (4) @(posedge clk_sys_i);
    check("skew irq", {31'h0, irq_o}, 32'h1);
    rd_chk("skew", lsf_pkg::OFF_STATUS, 32'h8, lsf_pkg::RESP_OKAY);
    wr(lsf_pkg::OFF_STATUS, 32'h8);
    check("skew cleared", {31'h0, irq_o}, 32'h0);
    give_verdict();
  end
endmodule : tb
